// ===== nvc_pkg.sv
// Package for the nonvolatile memory controller register front end
package nvc_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_ADDR_LOW   = 4'h0;
    localparam logic [3:0] OFF_ADDR_MID   = 4'h1;
    localparam logic [3:0] OFF_ADDR_EXT   = 4'h2;
    localparam logic [3:0] OFF_DATA_ZERO  = 4'h4;
    localparam logic [3:0] OFF_DATA_ONE   = 4'h5;
    localparam logic [3:0] OFF_DATA_TWO   = 4'h6;
    localparam logic [3:0] OFF_CMD        = 4'hA;
    localparam logic [3:0] OFF_EXEC       = 4'hB;
    localparam logic [3:0] OFF_PWR_MAP    = 4'hC;
    localparam logic [3:0] OFF_IRQ_LVL    = 4'hD;
    localparam logic [3:0] OFF_STATUS     = 4'hF;
    localparam logic [7:0] RST_ADDR_LOW   = 8'hFF;
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam int BIT_EXEC      = 0;
    localparam int BIT_LOCK      = 0;
    localparam int BIT_EEPROM_POWER_REDUCE      = 1;
    localparam int BIT_FLASH_POWER_REDUCE      = 2;
    localparam int BIT_MAPEN     = 3;
    localparam int BIT_FLASH_BUFFER_LOADED     = 0;
    localparam int BIT_EEPROM_BUFFER_LOADED    = 1;
    localparam int BIT_FLASH_BUSY_FLAG     = 6;
    localparam int BIT_MBUSY     = 7;
    localparam logic [7:0] MASK_CMD = 8'h7F;
    localparam logic [7:0] MASK_PWR = 8'h0F;
    localparam logic [7:0] MASK_IRQ = 8'h0F;
    // Protection window after the unlock key, in cycles
    localparam logic [2:0] CCP_WINDOW = 3'h4;
    localparam int WAKE_NS = 100;
    localparam int CLK_NS  = 5;
    localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    // Operation classes reported by the memory engine
    typedef enum logic [1:0] {NVC_OP_OTHER, NVC_OP_FLASH, NVC_OP_EEPROM, NVC_OP_LOCK} nvc_op_t;
    typedef struct packed {
        logic         wr;
        logic         rd;
        logic [3:0]   addr;
        logic [7:0]   wdata;
    } nvc_bus_t;
    typedef struct packed {
        logic [23:0]  addr;
        logic [23:0]  data;
        logic [6:0]   cmd;
    } nvc_cmd_t;
endpackage

// ===== nvc_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
`default_nettype none
module nvc_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            q_out  <= '0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ===== nvc_wake.sv
// Power-down section wake stall timer
`timescale 1ns/10ps
`default_nettype none
module nvc_wake #(
    parameter int CYC = 20
) (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic off_in,
    input  wire logic access_in,
    output logic      stall_out
);
    logic [15:0] cnt_r;
    logic        access_r;
    logic        start;
    // A held access wakes the section once, not again every period.
    // Limitation: an access already held when power-down begins is not stalled.
    assign start = off_in && access_in && !access_r && (cnt_r == 16'h0000);
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            access_r <= 1'b0;
        end else begin
            access_r <= access_in;
        end
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r     <= 16'h0000;
            stall_out <= 1'b0;
        end else if (start) begin
            cnt_r     <= 16'(CYC);
            stall_out <= 1'b1;
        end else if (cnt_r != 16'h0000) begin
            cnt_r     <= cnt_r - 16'h0001;
            stall_out <= (cnt_r != 16'h0001);
        end else begin
            stall_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== nvc_regs.sv
// Nonvolatile memory controller register front end
//
// Summary of operation
// - Mid address byte forms address 15:8
// - Extended address byte forms address 23:16
// - Data byte zero for every access
// - Data byte one for flash sections
// - Data byte two carries checksum top
// - Seven-bit command code, top external only
// - Protected execute strobe launches command
// - Protected write of one locks self-programming
// - Lock cleared only by reset
// - Mapping enable exposes EEPROM in data space
// - Flash reduction powers off idle section
// - EEPROM reduction powers it off, stalls masters
// - Self-program ready level interrupt when idle
// - EEPROM ready level interrupt when idle
// - Memory busy across any programming operation
// - Flash busy blocks application section
// - EEPROM buffer loaded until write or flush
// - Flash buffer loaded until write or flush
// - Low address byte resets to all ones
`timescale 1ns/10ps
`default_nettype none
module nvc_regs #(
    parameter int WAKE_CYCLES = nvc_pkg::WAKE_CYC
) (
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    input  wire nvc_pkg::nvc_bus_t bus_in,
    input  wire logic              ccp_unlock_in,
    input  wire logic              op_start_in,
    input  wire nvc_pkg::nvc_op_t  op_kind_in,
    input  wire logic              op_done_in,
    input  wire logic              eeprom_buf_load_in,
    input  wire logic              flash_buf_load_in,
    input  wire logic              eeprom_buf_clear_in,
    input  wire logic              flash_buf_clear_in,
    input  wire logic              running_boot_in,
    input  wire logic              flash_access_in,
    input  wire logic              eeprom_access_in,
    output logic [7:0]             rdata_out,
    output nvc_pkg::nvc_cmd_t      cmd_out,
    output logic                   execute_strobe_out,
    output logic                   self_program_lock_out,
    output logic                   eeprom_mapping_enable_out,
    output logic                   app_flash_on_out,
    output logic                   boot_flash_on_out,
    output logic                   eeprom_on_out,
    output logic                   app_section_block_out,
    output logic                   cpu_stall_out,
    output logic                   master_stall_out,
    output logic [1:0]             self_program_ready_level_out,
    output logic [1:0]             eeprom_ready_level_out
);
    import nvc_pkg::*;

    logic [7:0] addr_low_r, addr_mid_r, addr_ext_r;
    logic [7:0] data_byte_zero_r, data_byte_one_r, data_byte_two_r;
    logic [7:0] cmd_r, pwr_r, irq_r;
    logic       mbusy_r, flash_busy_flag_r, eeprom_buffer_loaded_r, flash_buffer_loaded_r;
    logic [2:0] ccp_cnt_r;
    logic       boot_s;
    logic       boot_sync;

    // Section selection is a pin, so it is synchronised first
    nvc_sync #(.W(1)) u_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .d_in     (running_boot_in),
        .q_out    (boot_s)
    );
    assign boot_sync = boot_s;

    wire wr_any   = bus_in.wr;
    wire wr_low   = wr_any && (bus_in.addr == OFF_ADDR_LOW);
    wire wr_mid   = wr_any && (bus_in.addr == OFF_ADDR_MID);
    wire wr_ext   = wr_any && (bus_in.addr == OFF_ADDR_EXT);
    wire wr_d0    = wr_any && (bus_in.addr == OFF_DATA_ZERO);
    wire wr_d1    = wr_any && (bus_in.addr == OFF_DATA_ONE);
    wire wr_d2    = wr_any && (bus_in.addr == OFF_DATA_TWO);
    wire wr_cmd   = wr_any && (bus_in.addr == OFF_CMD);
    wire wr_exec  = wr_any && (bus_in.addr == OFF_EXEC);
    wire wr_pwr   = wr_any && (bus_in.addr == OFF_PWR_MAP);
    wire wr_irq   = wr_any && (bus_in.addr == OFF_IRQ_LVL);
    wire ccp_open = (ccp_cnt_r != 3'h0);

    wire exec_go  = wr_exec && ccp_open && bus_in.wdata[BIT_EXEC];
    wire lock_set = wr_pwr && ccp_open && bus_in.wdata[BIT_LOCK];

    wire [7:0] pwr_nxt = {4'h0, bus_in.wdata[3:1] & MASK_PWR[3:1],
                          pwr_r[BIT_LOCK] | lock_set};

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ccp_cnt_r <= 3'h0;
        end else if (ccp_unlock_in) begin
            ccp_cnt_r <= CCP_WINDOW;
        end else if (ccp_open) begin
            ccp_cnt_r <= ccp_cnt_r - 3'h1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_low_r <= RST_ADDR_LOW;
        end else if (wr_low) begin
            addr_low_r <= bus_in.wdata;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_mid_r <= RST_ZERO;
            addr_ext_r <= RST_ZERO;
        end else begin
            if (wr_mid) begin
                addr_mid_r <= bus_in.wdata;
            end
            if (wr_ext) begin
                addr_ext_r <= bus_in.wdata;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_byte_zero_r <= RST_ZERO;
            data_byte_one_r <= RST_ZERO;
            data_byte_two_r <= RST_ZERO;
        end else begin
            if (wr_d0) begin
                data_byte_zero_r <= bus_in.wdata;
            end
            if (wr_d1) begin
                data_byte_one_r <= bus_in.wdata;
            end
            if (wr_d2) begin
                data_byte_two_r <= bus_in.wdata;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_r <= RST_ZERO;
        end else if (wr_cmd) begin
            cmd_r <= bus_in.wdata & MASK_CMD;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwr_r <= RST_ZERO;
        end else if (wr_pwr) begin
            pwr_r <= pwr_nxt;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_r <= RST_ZERO;
        end else if (wr_irq) begin
            irq_r <= bus_in.wdata & MASK_IRQ;
        end
    end

    // Busy flags, start wins over done
    wire mbusy_nxt = op_start_in ? 1'b1 : (op_done_in ? 1'b0 : mbusy_r);
    wire fstart    = op_start_in && (op_kind_in == NVC_OP_FLASH);
    wire flash_busy_flag_nxt = fstart ? 1'b1 : (op_done_in ? 1'b0 : flash_busy_flag_r);
    // Buffer loaded flags, load wins over clear
    wire eel_nxt   = eeprom_buf_load_in | (eeprom_buffer_loaded_r & ~eeprom_buf_clear_in);
    wire fl_nxt    = flash_buf_load_in | (flash_buffer_loaded_r & ~flash_buf_clear_in);

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mbusy_r  <= 1'b0;
            flash_busy_flag_r  <= 1'b0;
            eeprom_buffer_loaded_r <= 1'b0;
            flash_buffer_loaded_r  <= 1'b0;
        end else begin
            mbusy_r  <= mbusy_nxt;
            flash_busy_flag_r  <= flash_busy_flag_nxt;
            eeprom_buffer_loaded_r <= eel_nxt;
            flash_buffer_loaded_r  <= fl_nxt;
        end
    end

    logic [7:0] status_img;
    always_comb begin
        status_img              = 8'h00;
        status_img[BIT_MBUSY]   = mbusy_r;
        status_img[BIT_FLASH_BUSY_FLAG]   = flash_busy_flag_r;
        status_img[BIT_EEPROM_BUFFER_LOADED]  = eeprom_buffer_loaded_r;
        status_img[BIT_FLASH_BUFFER_LOADED]   = flash_buffer_loaded_r;
    end

    // Execute control reads zero: the strobe is self-clearing
    logic [7:0] rd_mux;
    always_comb begin
        case (bus_in.addr)
            OFF_ADDR_LOW:  rd_mux = addr_low_r;
            OFF_ADDR_MID:  rd_mux = addr_mid_r;
            OFF_ADDR_EXT:  rd_mux = addr_ext_r;
            OFF_DATA_ZERO: rd_mux = data_byte_zero_r;
            OFF_DATA_ONE:  rd_mux = data_byte_one_r;
            OFF_DATA_TWO:  rd_mux = data_byte_two_r;
            OFF_CMD:       rd_mux = cmd_r;
            OFF_PWR_MAP:   rd_mux = pwr_r;
            OFF_IRQ_LVL:   rd_mux = irq_r;
            OFF_STATUS:    rd_mux = status_img;
            default:       rd_mux = 8'h00;
        endcase
    end

    // With flash power reduction set, only the executing flash section stays powered
    wire flash_power_reduce     = pwr_r[BIT_FLASH_POWER_REDUCE];
    wire app_off  = flash_power_reduce && boot_sync;
    wire boot_off = flash_power_reduce && !boot_sync;
    wire f_off    = (app_off || boot_off) && flash_access_in;
    wire ee_off   = pwr_r[BIT_EEPROM_POWER_REDUCE];

    logic cpu_stall, master_stall;
    nvc_wake #(.CYC(WAKE_CYCLES)) u_fwake (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .off_in    (f_off),
        .access_in (flash_access_in),
        .stall_out (cpu_stall)
    );
    nvc_wake #(.CYC(WAKE_CYCLES)) u_ewake (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .off_in    (ee_off),
        .access_in (eeprom_access_in),
        .stall_out (master_stall)
    );

    // Levels only while memory is idle
    wire [1:0] spm_lvl = mbusy_nxt ? 2'b00 : irq_r[3:2];
    wire [1:0] ee_lvl  = mbusy_nxt ? 2'b00 : irq_r[1:0];

    // Read data is zero outside a read cycle
    wire [7:0] rdata_nxt = bus_in.rd ? rd_mux : RST_ZERO;
    nvc_cmd_t  cmd_nxt;
    assign cmd_nxt = '{addr: {addr_ext_r, addr_mid_r, addr_low_r},
                       data: {data_byte_two_r, data_byte_one_r, data_byte_zero_r},
                       cmd:  cmd_r[6:0]};

    // Read data stands for one cycle
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= RST_ZERO;
        end else begin
            rdata_out <= rdata_nxt;
        end
    end

    // Command image is re-timed with the registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_out <= '0;
        end else begin
            cmd_out <= cmd_nxt;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            execute_strobe_out <= 1'b0;
        end else begin
            execute_strobe_out <= exec_go;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            self_program_lock_out     <= 1'b0;
            eeprom_mapping_enable_out <= 1'b0;
        end else begin
            self_program_lock_out     <= pwr_r[BIT_LOCK];
            eeprom_mapping_enable_out <= pwr_r[BIT_MAPEN];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            app_flash_on_out  <= 1'b1;
            boot_flash_on_out <= 1'b1;
            eeprom_on_out     <= 1'b1;
        end else begin
            app_flash_on_out  <= !app_off;
            boot_flash_on_out <= !boot_off;
            eeprom_on_out     <= !ee_off;
        end
    end

    // Application section blocked while flash busy
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            app_section_block_out <= 1'b0;
        end else begin
            app_section_block_out <= flash_busy_flag_nxt;
        end
    end

    // Stalls leave a flop like every other output
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cpu_stall_out    <= 1'b0;
            master_stall_out <= 1'b0;
        end else begin
            cpu_stall_out    <= cpu_stall;
            master_stall_out <= master_stall;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            self_program_ready_level_out <= 2'b00;
            eeprom_ready_level_out       <= 2'b00;
        end else begin
            self_program_ready_level_out <= spm_lvl;
            eeprom_ready_level_out       <= ee_lvl;
        end
    end
endmodule
`default_nettype wire

// ===== nvc_regs_props.sv
// Checker for the nonvolatile memory controller register front end
`timescale 1ns/10ps
`default_nettype none
module nvc_regs_props (
    input wire logic              clock_in,
    input wire logic              rst_n_in,
    input wire nvc_pkg::nvc_bus_t bus_in,
    input wire logic              ccp_unlock_in,
    input wire logic              op_start_in,
    input wire nvc_pkg::nvc_op_t  op_kind_in,
    input wire logic              op_done_in,
    input wire logic [7:0]        rdata_out,
    input wire nvc_pkg::nvc_cmd_t cmd_out,
    input wire logic              execute_strobe_out,
    input wire logic              self_program_lock_out,
    input wire logic              eeprom_mapping_enable_out,
    input wire logic              app_section_block_out,
    input wire logic [1:0]        self_program_ready_level_out,
    input wire logic [1:0]        eeprom_ready_level_out
);
    import nvc_pkg::*;
    // Eight cycles of unlock history, wider than the window so refusals are certain
    logic [7:0] ccp_hist_r;
    logic       busy_r;
    wire        wr_mid = bus_in.wr && bus_in.addr == OFF_ADDR_MID;
    wire        wr_exe = bus_in.wr && bus_in.addr == OFF_EXEC && bus_in.wdata[BIT_EXEC];
    wire        wr_pwr = bus_in.wr && bus_in.addr == OFF_PWR_MAP;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ccp_hist_r <= 8'h00;
            busy_r     <= 1'b0;
        end else begin
            ccp_hist_r <= {ccp_hist_r[6:0], ccp_unlock_in};
            busy_r     <= op_start_in | (busy_r & ~op_done_in);
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    AST_IDLE_RDATA: assert property (!bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data not zero without a read");
    AST_CMD_TOP: assert property (bus_in.rd && bus_in.addr == OFF_CMD |=> !rdata_out[7])
        else $error("command top bit read back set");
    AST_EXEC_SRC: assert property (execute_strobe_out |-> $past(wr_exe))
        else $error("launch without an execute write");
    AST_EXEC_REFUSE: assert property (wr_exe && !ccp_unlock_in && ccp_hist_r == 8'h00 |=> !execute_strobe_out)
        else $error("launch accepted without unlock");
    AST_LOCK_SRC: assert property ($rose(self_program_lock_out) |-> $past(wr_pwr && bus_in.wdata[BIT_LOCK], 2))
        else $error("lock set without a lock write");
    AST_LOCK_HOLD: assert property (self_program_lock_out |=> self_program_lock_out)
        else $error("lock cleared without reset");
    AST_MAP_FOLLOW: assert property (wr_pwr |-> ##2 eeprom_mapping_enable_out == $past(bus_in.wdata[BIT_MAPEN], 2))
        else $error("mapping enable does not follow write");
    AST_STATUS_BUSY: assert property (bus_in.rd && bus_in.addr == OFF_STATUS |=> rdata_out[BIT_MBUSY] == $past(busy_r))
        else $error("busy flag wrong on status read");
    AST_LVL_IDLE: assert property (busy_r |-> self_program_ready_level_out == 2'b00 && eeprom_ready_level_out == 2'b00)
        else $error("ready request while busy");
    AST_FLASH_BUSY_FLAG_BLOCK: assert property (op_start_in && op_kind_in == NVC_OP_FLASH |=> app_section_block_out)
        else $error("application section not blocked");
    AST_ADDR_MID: assert property (wr_mid ##1 !wr_mid |=> cmd_out.addr[15:8] == $past(bus_in.wdata, 2))
        else $error("mid address byte not forwarded");
    cover property (execute_strobe_out);
    cover property (op_start_in ##[1:20] op_done_in);
    cover property ($rose(self_program_lock_out));
endmodule
bind nvc_regs nvc_regs_props i_props (
    .clock_in, .rst_n_in, .bus_in, .ccp_unlock_in, .op_start_in, .op_kind_in, .op_done_in,
    .rdata_out, .cmd_out, .execute_strobe_out, .self_program_lock_out,
    .eeprom_mapping_enable_out, .app_section_block_out,
    .self_program_ready_level_out, .eeprom_ready_level_out
);
`default_nettype wire

// ===== nvc_regs_tb.sv
// Self-checking bench for the nonvolatile memory controller register front end
`timescale 1ns/10ps
`default_nettype none
module nvc_regs_tb;
    import nvc_pkg::*;
    logic       clock_in = 1'b0;
    logic       rst_n_in = 1'b0;
    nvc_bus_t   bus = '0;
    nvc_op_t    kind = NVC_OP_OTHER;
    logic [6:0] pls = '0;
    logic       boot = 1'b0;
    logic [1:0] acc = '0;
    logic [7:0] rdata;
    nvc_cmd_t   cmd;
    logic       strobe, lock, map, app_on, boot_on, ee_on, blk, cst, mst;
    logic [1:0] spl, eel;
    wire  [1:0] stl = {cst, mst};
    logic [7:0] sh [16];
    logic [3:0] offs [10] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
    logic [7:0] d;
    int         seed = 2;
    int         n_fail = 0;
    int         total_checks = 0;
    int         n_exec = 0;
    int         cyc = 0;
    int         n;
    // Short wake count keeps the stall scenarios brief
    nvc_regs #(.WAKE_CYCLES(3)) i_dut (
        .clock_in, .rst_n_in, .bus_in(bus), .ccp_unlock_in(pls[6]), .op_start_in(pls[5]),
        .op_kind_in(kind), .op_done_in(pls[4]), .eeprom_buf_load_in(pls[3]),
        .flash_buf_load_in(pls[2]), .eeprom_buf_clear_in(pls[1]), .flash_buf_clear_in(pls[0]),
        .running_boot_in(boot), .flash_access_in(acc[1]), .eeprom_access_in(acc[0]),
        .rdata_out(rdata), .cmd_out(cmd), .execute_strobe_out(strobe),
        .self_program_lock_out(lock), .eeprom_mapping_enable_out(map), .app_flash_on_out(app_on),
        .boot_flash_on_out(boot_on), .eeprom_on_out(ee_on), .app_section_block_out(blk),
        .cpu_stall_out(cst), .master_stall_out(mst), .self_program_ready_level_out(spl),
        .eeprom_ready_level_out(eel)
    );
    always #2.5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cyc++;
        if (strobe === 1'b1) begin
            n_exec++;
        end
        if (cyc > 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    function automatic logic [7:0] exp_of(input logic [3:0] a, input logic [7:0] v);
        case (a)
            OFF_CMD: return v & MASK_CMD;
            // Lock bit is refused here: these writes carry no unlock
            OFF_PWR_MAP: return v & 8'h0E;
            OFF_IRQ_LVL: return v & MASK_IRQ;
            OFF_EXEC, OFF_STATUS: return 8'h00;
            default: return v;
        endcase
    endfunction
    task automatic tick();
        @(posedge clock_in);
        #1;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        bus = {1'b1, 1'b0, a, v};
        tick();
        bus = '0;
        tick();
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        bus = {1'b0, 1'b1, a, 8'h00};
        tick();
        bus = '0;
        chk(rdata, exp);
        tick();
    endtask
    task automatic pulse(input logic [6:0] p);
        pls = p;
        tick();
        pls = '0;
        tick();
    endtask
    task automatic unlock_wr(input logic [3:0] a, input logic [7:0] v);
        pulse(7'h40);
        wr(a, v);
    endtask
    task automatic stall(input int k);
        n = 0;
        acc[k] = 1'b1;
        repeat (10) begin
            tick();
            n += int'(stl[k]);
        end
        chk(24'(n != 0), 24'h1);
        chk(stl[k], 1'b0);
        acc[k] = 1'b0;
        tick();
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock_in);
        #1;
        rst_n_in = 1'b1;
        for (int i = 0; i < 16; i++) begin
            rd(4'(i), i == 0 ? 8'hFF : 8'h00);
        end
        repeat (4) begin
            foreach (offs[i]) begin
                d = 8'($random(seed));
                // Software keeps command top bit clear
                d = offs[i] == OFF_CMD ? d & MASK_CMD : d;
                wr(offs[i], d);
                sh[offs[i]] = exp_of(offs[i], d);
                rd(offs[i], sh[offs[i]]);
            end
            chk(cmd.addr, {sh[2], sh[1], 8'hFF});
            chk(cmd.data, {sh[6], sh[5], sh[4]});
            chk(cmd.cmd, sh[10][6:0]);
            chk(n_exec, 0);
        end
        unlock_wr(OFF_EXEC, 8'h01);
        chk(n_exec, 1);
        wr(OFF_PWR_MAP, 8'h0E);
        repeat (4) tick();
        chk({map, app_on, boot_on, ee_on}, 4'hC);
        boot = 1'b1;
        repeat (4) tick();
        chk({app_on, boot_on}, 2'b01);
        stall(1);
        stall(0);
        wr(OFF_PWR_MAP, 8'h00);
        chk({map, app_on, boot_on, ee_on}, 4'h7);
        for (int k = 1; k < 4; k++) begin
            kind = nvc_op_t'(k);
            pulse(7'h20);
            // Ready requests are enabled only once the launch is under way
            wr(OFF_IRQ_LVL, 8'h0F);
            chk({spl, eel, blk}, {4'h0, k == 1});
            rd(OFF_STATUS, k == 1 ? 8'hC0 : 8'h80);
            pulse(7'h10);
            chk({spl, eel, blk}, 5'h1E);
            wr(OFF_IRQ_LVL, 8'h00);
        end
        pulse(7'h08);
        rd(OFF_STATUS, 8'h02);
        pulse(7'h04);
        rd(OFF_STATUS, 8'h03);
        pulse(7'h0A);
        rd(OFF_STATUS, 8'h03);
        pulse(7'h02);
        rd(OFF_STATUS, 8'h01);
        pulse(7'h01);
        rd(OFF_STATUS, 8'h00);
        unlock_wr(OFF_PWR_MAP, 8'h01);
        chk(lock, 1'b1);
        unlock_wr(OFF_PWR_MAP, 8'h00);
        rd(OFF_PWR_MAP, 8'h01);
        rst_n_in = 1'b0;
        tick();
        rst_n_in = 1'b1;
        tick();
        chk(lock, 1'b0);
        rd(OFF_ADDR_LOW, 8'hFF);
        wrap_up();
    end
endmodule
`default_nettype wire
